// ### hw/irt_pkg.sv
// constants for the infrared conversion timing block
// assumes a 10 MHz system clock and an AXI4-Lite master outside
package irt_pkg;
   // =====================================================
   // register indices; the byte address is four times the index
   localparam logic [7:0] IRT_IDX_RECOVERY = 8'h1d;
   localparam logic [7:0] IRT_IDX_GAIN     = 8'h1e;
   localparam logic [7:0] IRT_IDX_RANGE    = 8'h1f;
   localparam logic [7:0] IRT_IDX_STATUS   = 8'h20;
   localparam logic [7:0] IRT_IDX_MASK     = 8'h21;
   localparam logic [7:0] IRT_IDX_CONTROL  = 8'h22;
   localparam logic [7:0] IRT_IDX_STATE    = 8'h23;
   localparam logic [9:0] IRT_ADDR_RECOVERY = {IRT_IDX_RECOVERY, 2'b00};
   localparam logic [9:0] IRT_ADDR_GAIN     = {IRT_IDX_GAIN, 2'b00};
   localparam logic [9:0] IRT_ADDR_RANGE    = {IRT_IDX_RANGE, 2'b00};
   localparam logic [9:0] IRT_ADDR_STATUS   = {IRT_IDX_STATUS, 2'b00};
   localparam logic [9:0] IRT_ADDR_MASK     = {IRT_IDX_MASK, 2'b00};
   localparam logic [9:0] IRT_ADDR_CONTROL  = {IRT_IDX_CONTROL, 2'b00};
   localparam logic [9:0] IRT_ADDR_STATE    = {IRT_IDX_STATE, 2'b00};
   // =====================================================
   // fields and reset values
   localparam int         IRT_REC_LSB      = 4;
   localparam int         IRT_RANGE_BIT    = 5;
   localparam logic [7:0] IRT_RECOVERY_RST = 8'h70;
   localparam logic [7:0] IRT_GAIN_RST     = 8'h00;
   localparam logic [7:0] IRT_RANGE_RST    = 8'h00;
   localparam logic [7:0] IRT_REC_MASK     = 8'h70;
   localparam logic [7:0] IRT_GAIN_MASK    = 8'h07;
   localparam logic [7:0] IRT_RANGE_MASK   = 8'h3f;
   // status bits: 0 ir done, 1 vis done
   localparam int         IRT_EVT_W        = 2;
   // =====================================================
   // timing
   localparam int IRT_BASE_CLK_NS  = 50;
   localparam int IRT_SYS_CLK_NS   = 100;
   localparam int IRT_VIS_CYCLES   = 4;
   localparam logic [1:0] IRT_RESP_OKAY   = 2'b00;
   localparam logic [1:0] IRT_RESP_SLVERR = 2'b10;

   typedef enum logic [3:0] {
      IRT_IDLE    = 4'b0001,
      IRT_RECOVER = 4'b0010,
      IRT_CONVERT = 4'b0100,
      IRT_VISIBLE = 4'b1000
   } irt_state_t;

   // recovery length in base adc clocks: code 0 gives 1, code n gives 2^(n+2)-1
   function automatic logic [9:0] irt_rec_clocks(input logic [2:0] code);
      irt_rec_clocks = (code == 3'h0) ? 10'h001 : (10'h004 << code) - 10'h001;
   endfunction
endpackage

// ### hw/irt_divider.sv
// adc clock divider: one tick every 2^gain enabled cycles
// assumes the caller restarts it at the start of each recovery and conversion phase; it runs free in idle
module irt_divider #(
   parameter int DIV_W = 8
) (
   // clock and control
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire logic            ce,
   input  wire logic            restart,
   input  wire logic [2:0]      gain,
   // tick out
   output logic                 tick
);
   if (DIV_W < 8) begin : g_width_chk
      $error("divider too narrow for gain 7");
   end
   logic [DIV_W-1:0] count;
   wire  [DIV_W-1:0] limit = DIV_W'((9'h001 << gain) - 9'h001);
   wire              at_end = (count >= limit);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (ce) begin
         count <= (restart || at_end) ? '0 : count + 1'b1;
         tick  <= !restart && at_end;
      end
   end
endmodule

// ### hw/irt_top.sv
// infrared conversion timing control with AXI4-Lite registers
// assumes one 10 MHz clock; start and conversion-done come from the adc sequencer
// Functional notes
// - Before each infrared measurement the block waits 1,7,15,...,511 adc clocks by code.
// - Each adc clock of recovery is 50 ns stretched by two to the gain; the code counts one aclk instead, 100 ns at 10 MHz.
// - Recovery resets to 0x70, gain and range to zero.
// - The adc clock is divided by two to the gain field.
// - Gain codes run up to 7 in bits 2:0, factor 128.
// - Range bit 5 selects normal (0) or high signal range (1).
// - The interrupt pin is open drain, pulled low only.
module irt_top #(
   parameter int ADDR_W = 10
) (
   // clock, reset, enable
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // adc sequencer
   input  wire logic              ir_start,
   input  wire logic              vis_start,
   input  wire logic              conv_done,
   output logic                   adc_sample,
   output logic                   adc_tick,
   output logic                   ambient_infrared_measurement,
   output logic                   ir_high_range_bit,
   output logic                   busy,
   // interrupt pin, open drain
   input  wire logic              int_in,
   output logic                   int_out,
   output logic                   int_oe_n
);
   import irt_pkg::*;

   // refused at elaboration: the map reaches byte address 0x8c
   if (ADDR_W < 10) begin : g_addr_chk
      $error("address too narrow for register map");
   end
   if (IRT_EVT_W > 6) begin : g_evt_chk
      $error("status view holds at most six event bits");
   end

   // =====================================================
   // registers
   logic [7:0]           recovery_reg;
   logic [7:0]           gain_reg;
   logic [7:0]           range_reg;
   logic [IRT_EVT_W-1:0] status;
   logic [IRT_EVT_W-1:0] mask;
   logic                 int_in_seen;
   irt_state_t           state;
   logic [9:0]           rec_left;
   logic [2:0]           vis_left;

   wire [2:0] ir_recovery_field         = recovery_reg[IRT_REC_LSB +: 3];
   wire [2:0] ir_integration_gain_field = gain_reg[2:0];

   // =====================================================
   // axi write channel: address and data taken in either order
   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;

   wire aw_take  = s_axi_awvalid && s_axi_awready;
   wire w_take   = s_axi_wvalid && s_axi_wready;
   wire wr_go    = aw_held && w_held && !s_axi_bvalid;
   wire wr_lane0 = wr_go && w_strb[0];
   wire [7:0] wr_byte = w_data[7:0];

   function automatic logic [3:0] irt_decode(input logic [ADDR_W-1:0] a);
      irt_decode = 4'h0;
      // misaligned addresses decode to nothing and answer with an error
      if (a[1:0] == 2'b00) begin
         unique case (10'(a))
            IRT_ADDR_RECOVERY: irt_decode = 4'h1;
            IRT_ADDR_GAIN:     irt_decode = 4'h2;
            IRT_ADDR_RANGE:    irt_decode = 4'h3;
            IRT_ADDR_STATUS:   irt_decode = 4'h4;
            IRT_ADDR_MASK:     irt_decode = 4'h5;
            IRT_ADDR_CONTROL:  irt_decode = 4'h6;
            IRT_ADDR_STATE:    irt_decode = 4'h7;
            default:           irt_decode = 4'h0;
         endcase
      end
   endfunction

   wire [3:0] wr_sel   = irt_decode(aw_addr);
   wire       wr_rec   = wr_lane0 && (wr_sel == 4'h1);
   wire       wr_gain  = wr_lane0 && (wr_sel == 4'h2);
   wire       wr_range = wr_lane0 && (wr_sel == 4'h3);
   wire       wr_stat  = wr_lane0 && (wr_sel == 4'h4);
   wire       wr_mask  = wr_lane0 && (wr_sel == 4'h5);
   wire       wr_ok    = (wr_sel != 4'h0) && (wr_sel != 4'h7);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= IRT_RESP_OKAY;
      end else if (ce) begin
         // a second write waits until its response has been taken
         s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !w_take && !s_axi_bvalid;
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? IRT_RESP_OKAY : IRT_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // =====================================================
   // axi read channel
   wire [3:0] rd_sel  = irt_decode(s_axi_araddr);
   wire       ar_take = s_axi_arvalid && s_axi_arready;
   wire [7:0] state_view = {3'h0, int_in_seen, state};
   wire [7:0] rd_byte =
      (rd_sel == 4'h1) ? recovery_reg :
      (rd_sel == 4'h2) ? gain_reg :
      (rd_sel == 4'h3) ? range_reg :
      (rd_sel == 4'h4) ? {6'h00, status} :
      (rd_sel == 4'h5) ? {6'h00, mask} :
      (rd_sel == 4'h7) ? state_view : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= IRT_RESP_OKAY;
      end else if (ce) begin
         // read data are captured with the address and stand until rready
         s_axi_arready <= !s_axi_rvalid && !ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= (rd_sel == 4'h0) ? IRT_RESP_SLVERR : IRT_RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // =====================================================
   // parameter entries
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         recovery_reg <= IRT_RECOVERY_RST;
         gain_reg     <= IRT_GAIN_RST;
         range_reg    <= IRT_RANGE_RST;
      end else if (ce) begin
         // recovery accepts any code, the inverse-of-gain pairing is advice only
         if (wr_rec) recovery_reg <= wr_byte & IRT_REC_MASK;
         // bits outside the gain field always read back as zero
         if (wr_gain) gain_reg <= wr_byte & IRT_GAIN_MASK;
         // reserved low bits are stored so a read-modify-write returns them
         if (wr_range) range_reg <= wr_byte & IRT_RANGE_MASK;
      end
   end

   // =====================================================
   // conversion sequencer
   logic       div_restart;
   logic       div_tick;
   irt_state_t next_state;

   wire       start_ir  = (state == IRT_IDLE) && ir_start;
   wire       start_vis = (state == IRT_IDLE) && !ir_start && vis_start;
   // a tick left over from the free-running idle count must not shorten recovery
   wire       tick_ok   = div_tick && !div_restart;
   wire       rec_last  = (state == IRT_RECOVER) && tick_ok && (rec_left == 10'h001);
   wire       ir_end    = (state == IRT_CONVERT) && conv_done;
   wire       vis_end   = (state == IRT_VISIBLE) && (vis_left == 3'h0);

   // one enabled aclk stands for one base adc clock; at 10 MHz that is 100 ns, not 50 ns,
   // so recovery times scale by two unless aclk runs at 20 MHz
   irt_divider #(.DIV_W(8)) u_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .restart (div_restart),
      .gain    (ir_integration_gain_field),
      .tick    (div_tick)
   );

   always_comb begin
      next_state = state;
      unique case (state)
         // infrared start wins when both starts arrive together
         IRT_IDLE:    if (start_ir) next_state = IRT_RECOVER;
                      else if (start_vis) next_state = IRT_VISIBLE;
         IRT_RECOVER: if (rec_last) next_state = IRT_CONVERT;
         IRT_CONVERT: if (ir_end) next_state = IRT_IDLE;
         IRT_VISIBLE: if (vis_end) next_state = IRT_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state       <= IRT_IDLE;
         rec_left    <= '0;
         vis_left    <= '0;
         div_restart <= 1'b1;
      end else if (ce) begin
         state       <= next_state;
         div_restart <= start_ir || rec_last;
         if (start_ir) rec_left <= irt_rec_clocks(ir_recovery_field);
         else if ((state == IRT_RECOVER) && tick_ok) rec_left <= rec_left - 10'h001;
         // visible path runs a fixed count, independent of ir settings
         if (start_vis) vis_left <= 3'(IRT_VIS_CYCLES - 1);
         else if (state == IRT_VISIBLE) vis_left <= vis_left - 3'h1;
      end
   end

   // =====================================================
   // event flags: a new event wins over a clear in the same cycle
   wire [IRT_EVT_W-1:0] evt = {vis_end, ir_end};
   wire [IRT_EVT_W-1:0] clr = wr_stat ? wr_byte[IRT_EVT_W-1:0] : '0;
   wire [IRT_EVT_W-1:0] next_status;

   for (genvar gi = 0; gi < IRT_EVT_W; gi++) begin : g_evt
      assign next_status[gi] = evt[gi] || (status[gi] && !clr[gi]);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status      <= '0;
         mask        <= '0;
         int_out     <= 1'b0;
         int_oe_n    <= 1'b1;
         int_in_seen <= 1'b0;
      end else if (ce) begin
         status      <= next_status;
         if (wr_mask) mask <= wr_byte[IRT_EVT_W-1:0];
         int_out     <= 1'b0;
         // the pin follows an enabled flag one cycle late
         int_oe_n    <= !(|(status & mask));
         // records a low line seen by the block; high level relies on the pull-up
         int_in_seen <= int_in_seen | !int_in;
      end
   end

   // =====================================================
   // sequencer outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         adc_sample  <= 1'b0;
         adc_tick    <= 1'b0;
         busy        <= 1'b0;
         ambient_infrared_measurement <= 1'b0;
         ir_high_range_bit            <= 1'b0;
      end else if (ce) begin
         adc_sample  <= (next_state == IRT_CONVERT);
         // adc_tick mirrors the divider one cycle later for the converter
         adc_tick    <= div_tick;
         busy        <= (next_state != IRT_IDLE);
         ambient_infrared_measurement <= (next_state == IRT_RECOVER) ||
                                         (next_state == IRT_CONVERT);
         ir_high_range_bit <= range_reg[IRT_RANGE_BIT];
      end
   end
endmodule

// ### tb/irt_assertions.sv
// checker for irt_top: sequencer, bus and interrupt pin relations
// assumes it is bound to irt_top and sees only that module's ports
module irt_assertions (
   // clock and enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // bus handshake
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // sequencer and pin
   input wire logic ir_start,
   input wire logic vis_start,
   input wire logic conv_done,
   input wire logic adc_sample,
   input wire logic ambient_infrared_measurement,
   input wire logic busy,
   input wire logic int_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // =========
   // start conditions
   sequence s_ir_go;
      ir_start && !busy && ce;
   endsequence
   sequence s_vis_go;
      vis_start && !ir_start && !busy && ce;
   endsequence
   // =========
   // properties
   a_int_pin_low:
      assert property (int_out == 1'b0) else $error("interrupt pin driven high");
   a_ir_recovers_first:
      assert property (s_ir_go |=> ambient_infrared_measurement && !adc_sample)
      else $error("infrared start skipped recovery");
   a_sample_in_meas:
      assert property (adc_sample |-> ambient_infrared_measurement)
      else $error("sampling outside infrared measurement");
   a_meas_is_busy:
      assert property (ambient_infrared_measurement |-> busy)
      else $error("measurement while not busy");
   a_vis_not_ir:
      assert property (s_vis_go |=> !ambient_infrared_measurement [*4])
      else $error("visible run entered infrared phase");
   a_conv_done_ends:
      assert property (adc_sample && conv_done && ce |=> !adc_sample)
      else $error("conversion did not end on done");
   a_write_resp_blocks:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_resp_blocks:
      assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while response pending");
endmodule

bind irt_top irt_assertions irt_assertions_inst (
   .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .ir_start(ir_start), .vis_start(vis_start),
   .conv_done(conv_done), .adc_sample(adc_sample), .busy(busy), .int_out(int_out),
   .ambient_infrared_measurement(ambient_infrared_measurement)
);

// ### tb/irt_adc_model.sv
// adc sequencer and interrupt line model facing irt_top
// assumes the block's clock and an external pull-up on the line
module irt_adc_model (
   // clock and mode
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic slow,
   // from the block
   input  wire logic adc_sample,
   input  wire logic int_out,
   input  wire logic int_oe_n,
   // to the block
   output logic      conv_done,
   output logic      int_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt;
   // =========
   // conversion ends after 2 or 6 sampling cycles
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 3'h0;
         conv_done <= 1'b0;
      end else begin
         conv_done <= adc_sample && !conv_done && cnt == (slow ? 3'h5 : 3'h1);
         cnt <= (adc_sample && !conv_done) ? cnt + 3'h1 : 3'h0;
      end
   end
   // pull-up holds the line high whenever released, power-up included
   assign int_line = int_oe_n ? 1'b1 : int_out;
endmodule

// ### tb/irt_top_tb.sv
// self-checking bench for irt_top over AXI4-Lite
// assumes irt_adc_model closes conversions and pulls up the line
module irt_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import irt_pkg::*;
   logic        aclk = 0, aresetn = 0, ce = 1, slow = 0, msk = 0;
   logic [9:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, v, x;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        ir_start = 0, vis_start = 0, awready, wready, bvalid, arready, rvalid;
   logic        conv_done, adc_sample, adc_tick, meas, hi_rng, busy, int_line, int_out, oe_n;
   logic [1:0]  bresp, rresp, r;
   int          mismatches = 0, n_tests = 0, seed = 32'he552e2b4, cyc, i;

   irt_top irt_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ir_start(ir_start), .vis_start(vis_start), .conv_done(conv_done),
      .adc_sample(adc_sample), .adc_tick(adc_tick), .ambient_infrared_measurement(meas),
      .ir_high_range_bit(hi_rng), .busy(busy), .int_in(int_line), .int_out(int_out),
      .int_oe_n(oe_n));
   irt_adc_model irt_adc_model_inst (.aclk(aclk), .aresetn(aresetn), .slow(slow),
      .adc_sample(adc_sample), .int_out(int_out), .int_oe_n(oe_n), .conv_done(conv_done),
      .int_line(int_line));

   initial begin
      forever #50 aclk = ~aclk;
   end
   // =========
   // checking and bus tasks
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      bready <= 0;
      chk("bresp", IRT_RESP_OKAY, bresp);
      if (n == 40) begin
         mismatches++;
         complete_run();
      end
   endtask
   task automatic rd(input logic [9:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      v = rdata;
      r = rresp;
      rready <= 0;
      if (n == 40) begin
         mismatches++;
         complete_run();
      end
   endtask
   task automatic rchk(input string nm, input logic [9:0] a, input logic [31:0] e);
      rd(a);
      chk(nm, e, v);
      chk("rresp", IRT_RESP_OKAY, r);
   endtask
   // recovery length in aclk cycles: the coded adc clock count stretched by 2^gain
   function automatic int rec_cycles(input logic [2:0] code, input logic [2:0] g);
      int steps[8] = '{1, 7, 15, 31, 63, 127, 255, 511};
      return steps[code] << g;
   endfunction
   // =========
   // one infrared run: recovery length, done flag, interrupt, clear
   task automatic ir_run(input logic [2:0] code, input logic [2:0] g, input logic sl);
      int e, n, t;
      e = rec_cycles(code, g);
      n = rec_cycles(code, 3'h0);
      t = 0;
      wr(IRT_ADDR_RECOVERY, {25'h0, code, 4'h0});
      wr(IRT_ADDR_GAIN, {29'h0, g});
      @(posedge aclk);
      slow <= sl;
      ir_start <= 1;
      @(posedge aclk);
      ir_start <= 0;
      // adc_tick trails the divider by a cycle; up to two idle ticks may fall in the count
      for (cyc = 1; cyc < 70000 && adc_sample !== 1'b1; cyc++) begin
         @(posedge aclk);
         t += int'(adc_tick);
      end
      chk("recovery in window", 1, cyc >= e + 2 && cyc <= e + 6);
      chk("recovery ticks", 1, t >= n && t <= n + 2);
      if (cyc == 70000) begin
         mismatches++;
         complete_run();
      end
      for (cyc = 0; cyc < 50 && busy !== 1'b0; cyc++) @(posedge aclk);
      if (cyc == 50) begin
         mismatches++;
         complete_run();
      end
      rchk("ir done", IRT_ADDR_STATUS, 32'h1);
      chk("int line", {31'h0, !msk}, {31'h0, int_line});
      wr(IRT_ADDR_STATUS, 32'h1);
      rchk("status cleared", IRT_ADDR_STATUS, 32'h0);
      chk("line released", 32'h1, {31'h0, int_line});
   endtask
   // =========
   // main sequence
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      rchk("recovery reset", IRT_ADDR_RECOVERY, 32'h70);
      rchk("gain reset", IRT_ADDR_GAIN, 32'h0);
      rchk("range reset", IRT_ADDR_RANGE, 32'h0);
      rchk("state idle", IRT_ADDR_STATE, 32'h1);
      wstrb <= 4'he;
      wr(IRT_ADDR_GAIN, 32'h7);
      wstrb <= 4'hf;
      rchk("strobe off", IRT_ADDR_GAIN, 32'h0);
      rd(10'h3fc);
      chk("unmapped resp", IRT_RESP_SLVERR, r);
      for (i = 0; i < 4; i++) begin
         rd(IRT_ADDR_RANGE);
         x = $random(seed);
         x = (i == 0) ? x & 32'h3f : (v & 32'h1f) | (x & 32'h20);
         wr(IRT_ADDR_RANGE, x);
         rchk("range", IRT_ADDR_RANGE, x);
         chk("high range", {31'h0, x[5]}, {31'h0, hi_rng});
      end
      for (i = 0; i < 8; i++) ir_run(~i[2:0], i[2:0], i[0]);
      for (i = 0; i < 2; i++) begin
         x = $random(seed);
         ir_run(x[2:0], {1'b0, x[4:3]}, x[5]);
      end
      wr(IRT_ADDR_MASK, 32'h1);
      msk = 1;
      ir_run(3'h0, 3'h7, 1'b0);
      rchk("line seen", IRT_ADDR_STATE, 32'h11);
      @(posedge aclk);
      ce <= 0;
      vis_start <= 1;
      repeat (8) @(posedge aclk);
      chk("frozen busy", 32'h0, {31'h0, busy});
      ce <= 1;
      @(posedge aclk);
      vis_start <= 0;
      @(posedge aclk);
      for (cyc = 0; cyc < 50 && busy !== 1'b0; cyc++) @(posedge aclk);
      chk("vis length", 1, cyc >= IRT_VIS_CYCLES - 1 && cyc <= IRT_VIS_CYCLES + 1);
      rchk("vis done", IRT_ADDR_STATUS, 32'h2);
      chk("masked line", 32'h1, {31'h0, int_line});
      wr(IRT_ADDR_STATUS, 32'h2);
      complete_run();
   end
endmodule
